//--- include/bsc_pkg.sv
package bsc_pkg;

    // Chain geometry
    localparam int BSC_CHAIN_LEN     = 111;
    localparam int BSC_CELL_MCLK     = 16;
    localparam int BSC_CELL_MODE_MID = 17;
    localparam int BSC_CELL_MODE_VAL = 18;
    localparam int BSC_CELL_ADDR_MSB = 19;
    localparam int BSC_ADDR_BITS     = 5;
    localparam int BSC_CELL_LOOP0    = 24;
    localparam int BSC_LOOP_STRIDE   = 3;
    localparam int BSC_LOOP_MID_OFS  = 0;
    localparam int BSC_LOOP_IN_OFS   = 1;
    localparam int BSC_LOOP_OUT_OFS  = 2;
    localparam int BSC_CELL_LOOP_OE  = 48;
    localparam int BSC_CELL_MON_SEL  = 65;
    localparam int BSC_CELL_INT      = 82;
    localparam int BSC_CELL_ACK_VAL  = 83;
    localparam int BSC_CELL_ACK_OE   = 84;
    localparam int BSC_CELL_WR       = 85;
    localparam int BSC_CELL_RD       = 86;
    localparam int BSC_CELL_ALE      = 87;
    localparam int BSC_CELL_CS_VAL   = 88;
    localparam int BSC_CELL_CS_MID   = 89;
    localparam int BSC_CELL_BUS      = 90;
    localparam int BSC_CELL_CBL_MID  = 91;
    localparam int BSC_CELL_CBL_VAL  = 92;
    localparam int BSC_CELL_TX_DRV   = 109;
    localparam int BSC_CELL_CLK_EDGE = 110;

    // Channel slice bases, indexed by channel number
    localparam int       BSC_CH_BASE [0:7] = '{57, 49, 74, 66, 101, 93, 8, 0};
    localparam logic [7:0] BSC_CH_REV        = 8'h33;

    // Slot order inside a normal slice
    localparam int BSC_SN_LOS  = 0;
    localparam int BSC_SN_RX_NEGATIVE_DATA = 1;
    localparam int BSC_SN_RX_POSITIVE_DATA = 2;
    localparam int BSC_SN_RCLK = 3;
    localparam int BSC_SN_OE   = 4;
    localparam int BSC_SN_TX_NEGATIVE_DATA = 5;
    localparam int BSC_SN_TX_POSITIVE_DATA = 6;
    localparam int BSC_SN_TX_DATA_CLOCK = 7;
    // Slot order inside a reversed slice
    localparam int BSC_SR_TX_DATA_CLOCK = 0;
    localparam int BSC_SR_TX_POSITIVE_DATA = 1;
    localparam int BSC_SR_TX_NEGATIVE_DATA = 2;
    localparam int BSC_SR_RCLK = 3;
    localparam int BSC_SR_RX_POSITIVE_DATA = 4;
    localparam int BSC_SR_RX_NEGATIVE_DATA = 5;
    localparam int BSC_SR_OE   = 6;
    localparam int BSC_SR_LOS  = 7;

    // Register map
    localparam logic [7:0]  BSC_ADR_CTRL    = 8'h00;
    localparam logic [7:0]  BSC_ADR_STATUS  = 8'h04;
    localparam logic [7:0]  BSC_ADR_UPDCNT  = 8'h08;
    localparam logic [31:0] BSC_CTRL_RESET  = 32'h0000_0001;
    localparam int          BSC_CTRL_EN_BIT = 0;
    localparam int          BSC_ST_EXT_BIT  = 0;
    localparam int          BSC_ST_LOE_BIT  = 1;
    localparam int          BSC_ST_TRST_BIT = 2;
    localparam int          BSC_ST_LPO_LSB  = 8;

    typedef struct packed {
        logic signal_absent_flag;
        logic rx_negative_data;
        logic rx_positive_data;
        logic rx_recovered_clock;
    } bsc_rx_t;

    typedef struct packed {
        logic tx_negative_data;
        logic tx_positive_data;
        logic tx_data_clock;
    } bsc_tx_t;

    typedef struct packed {
        bsc_rx_t [7:0] rx;
        logic [7:0]    rx_outputs_enable_n;
        logic [7:0]    loop_pin_out_value;
        logic [7:0]    loop_pins_drive_enable;
        logic          host_ack_value;
        logic          host_ack_drive_enable;
        logic          int_n;
    } bsc_pin_out_t;

    typedef struct packed {
        bsc_tx_t [7:0] tx;
        logic          master_clock;
        logic          mode_middle_level;
        logic          mode_value;
        logic [4:0]    host_address;
        logic [7:0]    loop_pin_in_value;
        logic [7:0]    loop_pin_middle_level;
        logic          monitor_channel_select;
        logic          write_strobe_n;
        logic          read_strobe_n;
        logic          address_latch;
        logic          chip_select_n;
        logic          chip_select_middle_level;
        logic          bus_style_select;
        logic          cable_choice_middle_level;
        logic          cable_choice_value;
        logic          transmit_driver_enable;
        logic          clock_edge_select;
    } bsc_pin_in_t;

    typedef struct packed {
        logic trst_n;
        logic tck;
        logic tdi;
        logic dr_select;
        logic capture;
        logic shift;
        logic update;
        logic extest;
        logic sample;
    } bsc_tap_t;

endpackage : bsc_pkg

//--- tb/bsc_tap_model.sv
`timescale 1ns/1ps
module bsc_tap_model (
    input  wire logic         sys_clk_i,
    input  wire logic         tdo_i,
    output bsc_pkg::bsc_tap_t tap_o
);
    import bsc_pkg::*;
    initial tap_o = '{trst_n: 1'h1, tck: 1'h1, default: 1'h0};
    task automatic instr(input logic e, input logic s);
        tap_o.extest <= e;
        tap_o.sample <= s;
    endtask : instr
    // Test reset level, low clears the chain and latch
    task automatic test_reset(input logic t);
        tap_o.trst_n <= t;
    endtask : test_reset
    // One controller state: c = {select, capture, shift, update}, one falling then one rising tck
    task automatic step(input logic [3:0] c, input logic d, output logic q);
        repeat (3) @(posedge sys_clk_i);
        q = tdo_i;
        {tap_o.dr_select, tap_o.capture, tap_o.shift, tap_o.update} <= c;
        tap_o.tdi <= c[1] ? d : ~tap_o.tdi;
        @(posedge sys_clk_i);
        tap_o.tck <= 1'h0;
        repeat (4) @(posedge sys_clk_i);
        tap_o.tck <= 1'h1;
    endtask : step
endmodule : bsc_tap_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import bsc_pkg::*;
    logic         sys_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tdo_o;
    logic [7:0]   wb_adr_i, lo, oe, t8;
    logic [3:0]   wb_sel_i;
    logic [31:0]  wb_dat_i, wb_dat_o;
    logic [15:0]  lfsr = 16'h1910;
    logic [110:0] v, g;
    logic [127:0] r;
    bsc_tap_t     tap_i;
    bsc_pin_out_t core_out_i, pin_out_o;
    bsc_pin_in_t  pin_in_i;
    logic [31:0]  exp_q[$];
    int           miscompares = 0, cmp_count = 0;
    int           oe_cell[8] = '{63, 55, 78, 70, 107, 99, 12, 4};
    bsc_pin_scan_chain i_bsc_pin_scan_chain (.sys_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tap_i, .tdo_o, .core_out_i, .pin_in_i, .pin_out_o);
    bsc_tap_model i_bsc_tap_model (.sys_clk_i, .tdo_i(tdo_o), .tap_o(tap_i));
    initial begin
        sys_clk_i = 1'h0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    function automatic logic [110:0] rv();
        for (int i = 0; i < 8; i++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            r = {r[111:0], lfsr};
        end
        return r[110:0];
    endfunction : rv
    task automatic chk(input string n, input logic [127:0] s, input logic [127:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic summarize();
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [31:0] e);
        int n;
        @(posedge sys_clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, s, d};
        if (!w) exp_q.push_back(e);
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        if (wb_ack_o !== 1'h1) begin
            miscompares++;
            summarize();
        end else begin
            {wb_cyc_i, wb_stb_i} <= 2'h0;
        end
    endtask : wb
    always @(posedge sys_clk_i) begin
        if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && exp_q.size() > 0) chk("rdata", wb_dat_o, exp_q.pop_front());
    end
    // Capture (optional), 111 shifts, update, idle; g collects tdo
    task automatic scan(input logic c, input logic [110:0] d, output logic [110:0] o);
        logic q;
        if (c) i_bsc_tap_model.step(4'hC, 1'h0, q);
        for (int i = 0; i < 111; i++) begin
            i_bsc_tap_model.step(4'hA, d[i], q);
            if (i > 0) o[i - 1] = q;
        end
        i_bsc_tap_model.step(4'h9, 1'h0, q);
        o[110] = q;
        i_bsc_tap_model.step(4'h0, 1'h0, q);
    endtask : scan
    task automatic pins(input logic [110:0] d);
        for (int k = 0; k < 8; k++) begin
            lo[k] = d[26 + 3 * k];
            oe[k] = d[oe_cell[k]];
        end
        chk("pins", {pin_out_o.loop_pin_out_value, pin_out_o.loop_pins_drive_enable, pin_out_o.rx_outputs_enable_n,
            pin_out_o.host_ack_value, pin_out_o.host_ack_drive_enable, pin_out_o.int_n},
            {lo, {8{d[48]}}, oe, d[83], d[84], d[82]});
        chk("rx", {pin_out_o.rx[7], pin_out_o.rx[0]},
            {d[0], d[1], d[2], d[3], d[64], d[62], d[61], d[60]});
    endtask : pins
    initial begin
        rst_n_i = 1'h0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        v = rv();
        pin_in_i = v[$bits(bsc_pin_in_t)-1:0];
        v = rv();
        core_out_i = v[$bits(bsc_pin_out_t)-1:0];
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'h1;
        wb(1'h0, BSC_ADR_CTRL, 32'h0, 4'hF, BSC_CTRL_RESET);
        wb(1'h0, 8'h40, 32'h0, 4'hF, 32'h0);
        wb(1'h1, BSC_ADR_CTRL, 32'h0, 4'hE, 32'h0);
        wb(1'h0, BSC_ADR_CTRL, 32'h0, 4'hF, 32'h1);
        i_bsc_tap_model.instr(1'h0, 1'h1);
        v = rv();
        scan(1'h1, v, g);
        t8 = {<<{g[7:0]}};
        chk("ch7", t8, {core_out_i.rx[7], core_out_i.rx_outputs_enable_n[7], pin_in_i.tx[7]});
        chk("ch0", g[64:57], {core_out_i.rx[0].signal_absent_flag, core_out_i.rx_outputs_enable_n[0],
            core_out_i.rx[0][2:0], pin_in_i.tx[0]});
        t8 = {<<{g[23:16]}};
        chk("addr", t8, {pin_in_i.master_clock, pin_in_i.mode_middle_level, pin_in_i.mode_value,
            pin_in_i.host_address});
        chk("misc", {g[110:109], g[92:82], g[65], g[48]}, {pin_in_i.clock_edge_select,
            pin_in_i.transmit_driver_enable, pin_in_i.cable_choice_value, pin_in_i.cable_choice_middle_level,
            pin_in_i.bus_style_select, pin_in_i.chip_select_middle_level, pin_in_i.chip_select_n,
            pin_in_i.address_latch, pin_in_i.read_strobe_n, pin_in_i.write_strobe_n,
            core_out_i.host_ack_drive_enable, core_out_i.host_ack_value, core_out_i.int_n,
            pin_in_i.monitor_channel_select, |core_out_i.loop_pins_drive_enable});
        for (int k = 0; k < 8; k++) chk("loop", g[24 + 3 * k +: 3], {core_out_i.loop_pin_out_value[k],
            pin_in_i.loop_pin_in_value[k], pin_in_i.loop_pin_middle_level[k]});
        chk("func", pin_out_o, core_out_i);
        i_bsc_tap_model.instr(1'h1, 1'h0);
        r[110:0] = rv() | (111'h1 << 48);
        scan(1'h0, r[110:0], g);
        chk("length", g, v);
        pins(r[110:0]);
        v = r[110:0];
        r[110:0] = rv() & ~(111'h1 << 48);
        scan(1'h0, r[110:0], g);
        chk("length", g, v);
        pins(r[110:0]);
        wb(1'h0, BSC_ADR_UPDCNT, 32'h0, 4'hF, 32'h3);
        wb(1'h0, BSC_ADR_STATUS, 32'h0, 4'hF, {16'h0, lo, 8'h5});
        wb(1'h1, BSC_ADR_CTRL, 32'h0, 4'hF, 32'h0);
        repeat (4) @(posedge sys_clk_i);
        chk("func", pin_out_o, core_out_i);
        scan(1'h1, rv(), g);
        wb(1'h0, BSC_ADR_UPDCNT, 32'h0, 4'hF, 32'h3);
        wb(1'h1, BSC_ADR_CTRL, 32'h1, 4'h1, 32'h0);
        i_bsc_tap_model.test_reset(1'h0);
        repeat (4) @(posedge sys_clk_i);
        chk("tdo", tdo_o, 1'h0);
        chk("func", pin_out_o, core_out_i);
        wb(1'h0, BSC_ADR_STATUS, 32'h0, 4'hF, 32'h0);
        i_bsc_tap_model.test_reset(1'h1);
        summarize();
    end
endmodule : testbench

//--- verilog/bsc_chan_cells.sv
`timescale 1ns/1ps
module bsc_chan_cells #(
    parameter bit REVERSED = 1'h0
) (
    input  bsc_pkg::bsc_rx_t rx_core_i,
    input  logic             rx_oe_core_i,
    input  bsc_pkg::bsc_tx_t tx_pin_i,
    input  logic [7:0]       upd_i,
    output logic [7:0]       cap_o,
    output bsc_pkg::bsc_rx_t rx_drv_o,
    output logic             rx_oe_drv_o
);
    import bsc_pkg::*;

    localparam int P_LOS  = REVERSED ? BSC_SR_LOS  : BSC_SN_LOS;
    localparam int P_RX_NEGATIVE_DATA = REVERSED ? BSC_SR_RX_NEGATIVE_DATA : BSC_SN_RX_NEGATIVE_DATA;
    localparam int P_RX_POSITIVE_DATA = REVERSED ? BSC_SR_RX_POSITIVE_DATA : BSC_SN_RX_POSITIVE_DATA;
    localparam int P_RCLK = REVERSED ? BSC_SR_RCLK : BSC_SN_RCLK;
    localparam int P_OE   = REVERSED ? BSC_SR_OE   : BSC_SN_OE;
    localparam int P_TX_NEGATIVE_DATA = REVERSED ? BSC_SR_TX_NEGATIVE_DATA : BSC_SN_TX_NEGATIVE_DATA;
    localparam int P_TX_POSITIVE_DATA = REVERSED ? BSC_SR_TX_POSITIVE_DATA : BSC_SN_TX_POSITIVE_DATA;
    localparam int P_TX_DATA_CLOCK = REVERSED ? BSC_SR_TX_DATA_CLOCK : BSC_SN_TX_DATA_CLOCK;

    always_comb begin
        cap_o                       = '0;
        cap_o[P_LOS]                = rx_core_i.signal_absent_flag;
        cap_o[P_RX_NEGATIVE_DATA]               = rx_core_i.rx_negative_data;
        cap_o[P_RX_POSITIVE_DATA]               = rx_core_i.rx_positive_data;
        cap_o[P_RCLK]               = rx_core_i.rx_recovered_clock;
        cap_o[P_OE]                 = rx_oe_core_i;
        cap_o[P_TX_NEGATIVE_DATA]               = tx_pin_i.tx_negative_data;
        cap_o[P_TX_POSITIVE_DATA]               = tx_pin_i.tx_positive_data;
        cap_o[P_TX_DATA_CLOCK]               = tx_pin_i.tx_data_clock;
        rx_drv_o.signal_absent_flag = upd_i[P_LOS];
        rx_drv_o.rx_negative_data   = upd_i[P_RX_NEGATIVE_DATA];
        rx_drv_o.rx_positive_data   = upd_i[P_RX_POSITIVE_DATA];
        rx_drv_o.rx_recovered_clock = upd_i[P_RCLK];
        rx_oe_drv_o                 = upd_i[P_OE];
    end

endmodule : bsc_chan_cells

//--- verilog/bsc_pin_scan_chain.sv
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module bsc_pin_scan_chain #(
    parameter int UPD_CNT_W = 16
) (
    input  logic                  sys_clk_i,
    input  logic                  rst_n_i,
    input  logic                  wb_cyc_i,
    input  logic                  wb_stb_i,
    input  logic                  wb_we_i,
    input  logic [7:0]            wb_adr_i,
    input  logic [3:0]            wb_sel_i,
    input  logic [31:0]           wb_dat_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    input  bsc_pkg::bsc_tap_t     tap_i,
    output logic                  tdo_o,
    input  bsc_pkg::bsc_pin_out_t core_out_i,
    input  bsc_pkg::bsc_pin_in_t  pin_in_i,
    output bsc_pkg::bsc_pin_out_t pin_out_o
);
    import bsc_pkg::*;

    if (UPD_CNT_W < 1 || UPD_CNT_W > 32) begin : g_bad_width
        $error("UPD_CNT_W must lie in 1..32");
    end

    // Synchronisers for the test port and the pins
    bsc_tap_t    tap_s1_ff, tap_s2_ff;
    bsc_pin_in_t pin_s1_ff, pin_s2_ff;
    logic        tck_d_ff;
    bsc_tap_t    nxt_tap_s1, nxt_tap_s2;
    bsc_pin_in_t nxt_pin_s1, nxt_pin_s2;
    logic        nxt_tck_d;

    always_comb begin
        nxt_tap_s1 = tap_i;
        nxt_tap_s2 = tap_s1_ff;
        nxt_pin_s1 = pin_in_i;
        nxt_pin_s2 = pin_s1_ff;
        nxt_tck_d  = tap_s2_ff.tck;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tap_s1_ff <= '0;
            tap_s2_ff <= '0;
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            tck_d_ff  <= 1'h0;
        end else begin
            tap_s1_ff <= nxt_tap_s1;
            tap_s2_ff <= nxt_tap_s2;
            pin_s1_ff <= nxt_pin_s1;
            pin_s2_ff <= nxt_pin_s2;
            tck_d_ff  <= nxt_tck_d;
        end
    end

    // Control register and derived strobes
    logic [31:0]          ctrl_ff;
    logic [BSC_CHAIN_LEN-1:0] chain_ff, latch_ff;
    logic                 tdo_ff;
    logic [UPD_CNT_W-1:0] upd_cnt_ff;
    logic                 scan_en, tck_rise, tck_fall, dr_sel, cap_fire, shift_fire, upd_fire, extest;

    assign scan_en    = ctrl_ff[BSC_CTRL_EN_BIT] & tap_s2_ff.trst_n;
    assign tck_rise   = tap_s2_ff.tck & ~tck_d_ff;
    assign tck_fall   = ~tap_s2_ff.tck & tck_d_ff;
    assign dr_sel     = scan_en & tap_s2_ff.dr_select;
    assign cap_fire   = tck_rise & dr_sel & tap_s2_ff.capture & (tap_s2_ff.extest | tap_s2_ff.sample);
    assign shift_fire = tck_rise & dr_sel & tap_s2_ff.shift & ~tap_s2_ff.capture;
    assign upd_fire   = tck_fall & dr_sel & tap_s2_ff.update;
    assign extest     = scan_en & tap_s2_ff.extest;

    // Capture vector, one bit per cell
    wire [BSC_CHAIN_LEN-1:0] cap_vec;
    bsc_rx_t [7:0]           rx_drv;
    logic [7:0]              rx_oe_drv;
    logic [7:0]              lpo_upd;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_ch
            bsc_chan_cells #(
                .REVERSED (BSC_CH_REV[g])
            ) u_cells (
                .rx_core_i    (core_out_i.rx[g]),
                .rx_oe_core_i (core_out_i.rx_outputs_enable_n[g]),
                .tx_pin_i     (pin_s2_ff.tx[g]),
                .upd_i        (latch_ff[BSC_CH_BASE[g] +: 8]),
                .cap_o        (cap_vec[BSC_CH_BASE[g] +: 8]),
                .rx_drv_o     (rx_drv[g]),
                .rx_oe_drv_o  (rx_oe_drv[g])
            );
            localparam int LB = BSC_CELL_LOOP0 + g * BSC_LOOP_STRIDE;
            assign cap_vec[LB + BSC_LOOP_MID_OFS] = pin_s2_ff.loop_pin_middle_level[g];
            assign cap_vec[LB + BSC_LOOP_IN_OFS]  = pin_s2_ff.loop_pin_in_value[g];
            assign cap_vec[LB + BSC_LOOP_OUT_OFS] = core_out_i.loop_pin_out_value[g];
            assign lpo_upd[g]                     = latch_ff[LB + BSC_LOOP_OUT_OFS];
        end
        for (g = 0; g < BSC_ADDR_BITS; g++) begin : g_adr
            assign cap_vec[BSC_CELL_ADDR_MSB + g] = pin_s2_ff.host_address[BSC_ADDR_BITS-1-g];
        end
    endgenerate

    assign cap_vec[BSC_CELL_MCLK]     = pin_s2_ff.master_clock;
    assign cap_vec[BSC_CELL_MODE_MID] = pin_s2_ff.mode_middle_level;
    assign cap_vec[BSC_CELL_MODE_VAL] = pin_s2_ff.mode_value;
    assign cap_vec[BSC_CELL_LOOP_OE]  = |core_out_i.loop_pins_drive_enable;
    assign cap_vec[BSC_CELL_MON_SEL]  = pin_s2_ff.monitor_channel_select;
    assign cap_vec[BSC_CELL_INT]      = core_out_i.int_n;
    assign cap_vec[BSC_CELL_ACK_VAL]  = core_out_i.host_ack_value;
    assign cap_vec[BSC_CELL_ACK_OE]   = core_out_i.host_ack_drive_enable;
    assign cap_vec[BSC_CELL_WR]       = pin_s2_ff.write_strobe_n;
    assign cap_vec[BSC_CELL_RD]       = pin_s2_ff.read_strobe_n;
    assign cap_vec[BSC_CELL_ALE]      = pin_s2_ff.address_latch;
    assign cap_vec[BSC_CELL_CS_VAL]   = pin_s2_ff.chip_select_n;
    assign cap_vec[BSC_CELL_CS_MID]   = pin_s2_ff.chip_select_middle_level;
    assign cap_vec[BSC_CELL_BUS]      = pin_s2_ff.bus_style_select;
    assign cap_vec[BSC_CELL_CBL_MID]  = pin_s2_ff.cable_choice_middle_level;
    assign cap_vec[BSC_CELL_CBL_VAL]  = pin_s2_ff.cable_choice_value;
    assign cap_vec[BSC_CELL_TX_DRV]   = pin_s2_ff.transmit_driver_enable;
    assign cap_vec[BSC_CELL_CLK_EDGE] = pin_s2_ff.clock_edge_select;

    // Shift path, update latch and serial output
    logic [BSC_CHAIN_LEN-1:0] nxt_chain, nxt_latch;
    logic                     nxt_tdo;
    logic [UPD_CNT_W-1:0]     nxt_upd_cnt;

    always_comb begin
        nxt_chain   = chain_ff;
        nxt_latch   = latch_ff;
        nxt_tdo     = tdo_ff;
        nxt_upd_cnt = upd_cnt_ff;
        if (!tap_s2_ff.trst_n) begin
            nxt_chain = '0;
            nxt_latch = '0;
            nxt_tdo   = 1'h0;
        end else begin
            if (cap_fire) begin
                nxt_chain = cap_vec;
            end else if (shift_fire) begin
                nxt_chain = {tap_s2_ff.tdi, chain_ff[BSC_CHAIN_LEN-1:1]};
            end
            if (tck_fall) begin
                nxt_tdo = chain_ff[0];
            end
            if (upd_fire) begin
                nxt_latch   = chain_ff;
                nxt_upd_cnt = upd_cnt_ff + UPD_CNT_W'(1'h1);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            chain_ff   <= '0;
            latch_ff   <= '0;
            tdo_ff     <= 1'h0;
            upd_cnt_ff <= '0;
        end else begin
            chain_ff   <= nxt_chain;
            latch_ff   <= nxt_latch;
            tdo_ff     <= nxt_tdo;
            upd_cnt_ff <= nxt_upd_cnt;
        end
    end
    assign tdo_o = tdo_ff;

    // Pin drive selection
    bsc_pin_out_t pin_out_ff, nxt_pin_out;

    always_comb begin
        nxt_pin_out = core_out_i;
        if (extest) begin
            nxt_pin_out.rx                     = rx_drv;
            nxt_pin_out.rx_outputs_enable_n    = rx_oe_drv;
            nxt_pin_out.loop_pin_out_value     = lpo_upd;
            nxt_pin_out.loop_pins_drive_enable = {8{latch_ff[BSC_CELL_LOOP_OE]}};
            nxt_pin_out.host_ack_value         = latch_ff[BSC_CELL_ACK_VAL];
            nxt_pin_out.host_ack_drive_enable  = latch_ff[BSC_CELL_ACK_OE];
            nxt_pin_out.int_n                  = latch_ff[BSC_CELL_INT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pin_out_ff <= '0;
        end else begin
            pin_out_ff <= nxt_pin_out;
        end
    end
    assign pin_out_o = pin_out_ff;

    // Wishbone slave
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic        nxt_ack;
    logic [31:0] nxt_dat, nxt_ctrl;

    always_comb begin
        nxt_ack  = wb_cyc_i & wb_stb_i & ~ack_ff;
        nxt_dat  = '0;
        nxt_ctrl = ctrl_ff;
        if (nxt_ack) begin
            unique case (wb_adr_i)
                BSC_ADR_CTRL: begin
                    nxt_dat = ctrl_ff;
                    if (wb_we_i && wb_sel_i[0]) begin
                        nxt_ctrl[BSC_CTRL_EN_BIT] = wb_dat_i[BSC_CTRL_EN_BIT];
                    end
                end
                BSC_ADR_STATUS: begin
                    nxt_dat[BSC_ST_EXT_BIT]             = extest;
                    nxt_dat[BSC_ST_LOE_BIT]             = latch_ff[BSC_CELL_LOOP_OE];
                    nxt_dat[BSC_ST_TRST_BIT]            = tap_s2_ff.trst_n;
                    nxt_dat[BSC_ST_LPO_LSB +: 8]        = lpo_upd;
                end
                BSC_ADR_UPDCNT: begin
                    nxt_dat[UPD_CNT_W-1:0] = upd_cnt_ff;
                end
                default: begin
                    nxt_dat = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ack_ff  <= 1'h0;
            dat_ff  <= '0;
            ctrl_ff <= BSC_CTRL_RESET;
        end else begin
            ack_ff  <= nxt_ack;
            dat_ff  <= nxt_dat;
            ctrl_ff <= nxt_ctrl;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_shift_order: assert property (shift_fire |=>
                                      chain_ff == {$past(tap_s2_ff.tdi), $past(chain_ff[110:1])})
        else $error("chain did not shift toward cell 0");
    chk_capture_load: assert property (cap_fire |=> chain_ff == $past(cap_vec))
        else $error("capture did not load pin values");
    chk_latch_hold: assert property ((tap_s2_ff.trst_n && !upd_fire) ##1 tap_s2_ff.trst_n |->
                                     $stable(latch_ff))
        else $error("update latch changed outside update");
    chk_loop_enable: assert property (extest |=>
                                      pin_out_o.loop_pins_drive_enable == {8{$past(latch_ff[48])}})
        else $error("loop pin enable not taken from cell 48");
    chk_loop_value: assert property (extest |=> pin_out_o.loop_pin_out_value[0] == $past(latch_ff[26])
                                     && pin_out_o.loop_pin_out_value[7] == $past(latch_ff[47]))
        else $error("loop pin value not taken from output cell");
    chk_rx_enable: assert property (extest |=> pin_out_o.rx_outputs_enable_n[7] == $past(latch_ff[4])
                                    && pin_out_o.rx_outputs_enable_n[4] == $past(latch_ff[107]))
        else $error("receive enable not taken from its cell");
    chk_ack_drive: assert property (extest |=> pin_out_o.host_ack_drive_enable == $past(latch_ff[84])
                                    && pin_out_o.host_ack_value == $past(latch_ff[83]))
        else $error("ack pin not driven from cells 83 and 84");
    chk_functional_path: assert property (!extest |=> pin_out_o == $past(core_out_i))
        else $error("pins not driven by functional logic");
    chk_addr_cells: assert property (cap_fire |=> chain_ff[16] == $past(pin_s2_ff.master_clock)
                                     && chain_ff[19] == $past(pin_s2_ff.host_address[4])
                                     && chain_ff[23] == $past(pin_s2_ff.host_address[0]))
        else $error("clock or address cell misplaced");
    chk_tri_cells: assert property (cap_fire |=> chain_ff[17] == $past(pin_s2_ff.mode_middle_level)
                                    && chain_ff[89] == $past(pin_s2_ff.chip_select_middle_level)
                                    && chain_ff[92] == $past(pin_s2_ff.cable_choice_value))
        else $error("three-level cell misplaced");
    chk_misc_cells: assert property (cap_fire |=> chain_ff[65] == $past(pin_s2_ff.monitor_channel_select)
                                     && chain_ff[110] == $past(pin_s2_ff.clock_edge_select))
        else $error("misc cell misplaced");
    chk_rev_channel: assert property (cap_fire |=> chain_ff[49] == $past(pin_s2_ff.tx[1].tx_data_clock)
                                      && chain_ff[64] == $past(core_out_i.rx[0].signal_absent_flag))
        else $error("reversed channel cell misplaced");
    chk_wb_ack: assert property ((wb_cyc_i && wb_stb_i && !ack_ff) |=> ack_ff ##1 !ack_ff)
        else $error("bus ack not a single cycle");

    cov_capture: cover property (cap_fire);
    cov_shift_update: cover property (shift_fire ##[1:1000] upd_fire);
    cov_extest_loop: cover property (extest && latch_ff[48]);
    cov_bus_write: cover property (wb_ack_o && wb_we_i);

endmodule : bsc_pin_scan_chain
